// file: design/sfcfe_params.svh
/*
 * Constants for the serial flash command front end: opcodes, byte counts,
 * address limits, bit positions and page size.
 * Assumes inclusion by bare name from the design files; holds definitions only.
 */
`ifndef SFCFE_PARAMS_SVH
`define SFCFE_PARAMS_SVH

// ==========================================================================
// opcodes
`define SFCFE_OP_READ_FAST  8'h0B
`define SFCFE_OP_READ_SLOW  8'h03
`define SFCFE_OP_READ_DUAL  8'h3B
`define SFCFE_OP_PAGE_ERASE 8'h81
`define SFCFE_OP_ERASE_4K   8'h20
`define SFCFE_OP_ERASE_32A  8'h52
`define SFCFE_OP_ERASE_32B  8'hD8
`define SFCFE_OP_CHIP_A     8'h60
`define SFCFE_OP_CHIP_B     8'hC7
`define SFCFE_OP_CHIP_OLD   8'h62
`define SFCFE_OP_PROGRAM    8'h02
`define SFCFE_OP_WR_EN      8'h06
`define SFCFE_OP_WR_DIS     8'h04
`define SFCFE_OP_OTP_PROG   8'h9B
`define SFCFE_OP_OTP_READ   8'h77
`define SFCFE_OP_STAT_READ  8'h05
`define SFCFE_OP_STAT_WR1   8'h01
`define SFCFE_OP_STAT_WR2   8'h31
`define SFCFE_OP_RESET      8'hF0
`define SFCFE_OP_ID_READ    8'h9F
`define SFCFE_OP_ID_OLD     8'h15
`define SFCFE_OP_DPD        8'hB9
`define SFCFE_OP_RESUME     8'hAB
`define SFCFE_OP_UDPD       8'h79

// ==========================================================================
// framing figures
`define SFCFE_ADDR_BYTES    3'h3
`define SFCFE_DUMMY_NONE    2'h0
`define SFCFE_DUMMY_ONE     2'h1
`define SFCFE_DUMMY_TWO     2'h2
`define SFCFE_BIT_LAST      3'h7
`define SFCFE_DUAL_LAST     3'h3
`define SFCFE_ADDR_W        15
`define SFCFE_ADDR_ZERO     15'h0000
`define SFCFE_ADDR_ONE      15'h0001
`define SFCFE_PAGE_BYTES    9'h100

`endif

// file: design/sfcfe_pkg.sv
/*
 * Types for the serial flash command front end.
 * Assumes sfcfe_params.svh for the numeric constants.
 */
package sfcfe_pkg;

   // ==========================================================================
   // transaction phase
   typedef enum logic [2:0]
   {
      SFCFE_OPC   = 3'b000,
      SFCFE_ADDR  = 3'b001,
      SFCFE_DUMMY = 3'b010,
      SFCFE_DATA  = 3'b011,
      SFCFE_READ  = 3'b100,
      SFCFE_DEAF  = 3'b101
   } sfcfe_phase_e;

   // ==========================================================================
   // command classes for the execution logic; NONE, status, ID and OTP read classes are never handed on
   typedef enum logic [3:0]
   {
      SFCFE_CMD_NONE     = 4'h0,
      SFCFE_CMD_PAGE_ER  = 4'h1,
      SFCFE_CMD_ER_4K    = 4'h2,
      SFCFE_CMD_ER_32K   = 4'h3,
      SFCFE_CMD_CHIP_ER  = 4'h4,
      SFCFE_CMD_PROGRAM  = 4'h5,
      SFCFE_CMD_OTP_PROG = 4'h6,
      SFCFE_CMD_OTP_READ = 4'h7,
      SFCFE_CMD_STAT_RD  = 4'h8,
      SFCFE_CMD_STAT_WR1 = 4'h9,
      SFCFE_CMD_STAT_WR2 = 4'hA,
      SFCFE_CMD_ID_READ  = 4'hB,
      SFCFE_CMD_ID_OLD   = 4'hC,
      SFCFE_CMD_DPD      = 4'hD,
      SFCFE_CMD_RESUME   = 4'hE,
      SFCFE_CMD_MISC     = 4'hF
   } sfcfe_cmd_e;

endpackage

// file: design/sfcfe_front_end.sv
/*
 * Device-side command front end of a serial flash: frames each transaction
 * by chip select, decodes the opcode, gathers address, dummy and data bytes,
 * serves single and dual-output array reads and hands on other known commands except status, ID and OTP reads.
 * Assumes serial clock, chip select and data input arrive asynchronously and
 * are far slower than ref_clk (at least four ref_clk periods per half clock).
 * The array is outside: rd_addr is offered and rd_data must be valid on the
 * next ref_clk edge.
 */
// Notes on behaviour
// - all bytes travel most significant bit first
// - unknown opcode: ignore input until reselect
// - early deselect starts nothing, returns idle
// - only low fifteen address bits used
// - fast read expects one dummy byte
// - dual read: address, one dummy byte
// - dual read drives two bits per clock
// - read address counter advances automatically
// - read wraps from top to zero
// - deselect ends read, outputs released
// - 20h and 81h: three address bytes
// - 52h and D8h: 32K block erase
// - 60h, C7h, 62h: chip erase
// - 02h: address then 1..256 data bytes
// - 9Bh: OTP program, address plus data
// - 77h: address then two dummy bytes
// - 05h: status read, no address
// - 01h, 31h: one status data byte
// - 9Fh and 15h: identification reads
// - B9h, ABh, 79h: power commands
// - sample on rising, shift on falling
// - dual read turns input into output
`include "sfcfe_params.svh"

module sfcfe_front_end
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // serial link pins
   input wire logic serial_clk,
   input wire logic chip_sel_n,
   input wire logic second_output_line_in,
   output logic second_output_line_out,
   output logic second_output_line_oe,
   output logic data_out,
   output logic data_out_oe,
   // array read port
   output logic [14:0] rd_addr,
   input wire logic [7:0] rd_data,
   // command hand-over
   output logic cmd_valid,
   output sfcfe_pkg::sfcfe_cmd_e cmd_kind,
   output logic [7:0] cmd_opcode,
   output logic [14:0] cmd_addr,
   output logic [8:0] cmd_count,
   output logic [7:0] cmd_data
);

   // ==========================================================================
   // synchronisers
   logic [1:0] sck_sync;
   logic [1:0] cs_sync;
   logic [1:0] si_sync;
   logic sck_prev;

   // two flops per pin; only the second stage feeds logic
   always_ff @(posedge ref_clk)
   begin
      sck_sync <= {sck_sync[0], serial_clk};
      cs_sync <= {cs_sync[0], chip_sel_n};
      si_sync <= {si_sync[0], second_output_line_in};
      sck_prev <= sck_sync[1];
   end

   wire sck_rise = sck_sync[1] & ~sck_prev;
   wire sck_fall = ~sck_sync[1] & sck_prev;
   wire selected = ~cs_sync[1];

   // ==========================================================================
   // state
   sfcfe_pkg::sfcfe_phase_e phase;
   logic [2:0] bit_cnt;
   logic [7:0] shift_in;
   logic [7:0] opcode;
   logic [1:0] addr_cnt;
   logic [1:0] dummy_cnt;
   logic [14:0] addr;
   logic [8:0] data_cnt;
   logic [7:0] last_data;
   logic [7:0] out_shift;
   logic dual;
   logic byte_edge;

   // ==========================================================================
   // opcode decode: class, address use and dummy count
   wire [7:0] op_next = {shift_in[6:0], si_sync[1]};
   sfcfe_pkg::sfcfe_cmd_e dec_kind;
   logic dec_addr;
   logic [1:0] dec_dummy;
   logic dec_read;
   logic dec_known;

   // combinational lookup; unlisted codes leave dec_known low
   always_comb
   begin
      dec_kind = sfcfe_pkg::SFCFE_CMD_NONE;
      dec_addr = 1'b0;
      dec_dummy = `SFCFE_DUMMY_NONE;
      dec_read = 1'b0;
      dec_known = 1'b1;
      case (op_next)
         `SFCFE_OP_READ_FAST:
         begin
            dec_addr = 1'b1;
            dec_dummy = `SFCFE_DUMMY_ONE;
            dec_read = 1'b1;
         end
         `SFCFE_OP_READ_SLOW:
         begin
            dec_addr = 1'b1;
            dec_read = 1'b1;
         end
         `SFCFE_OP_READ_DUAL:
         begin
            dec_addr = 1'b1;
            dec_dummy = `SFCFE_DUMMY_ONE;
            dec_read = 1'b1;
         end
         `SFCFE_OP_PAGE_ERASE:
         begin
            dec_addr = 1'b1;
            dec_kind = sfcfe_pkg::SFCFE_CMD_PAGE_ER;
         end
         `SFCFE_OP_ERASE_4K:
         begin
            dec_addr = 1'b1;
            dec_kind = sfcfe_pkg::SFCFE_CMD_ER_4K;
         end
         `SFCFE_OP_ERASE_32A, `SFCFE_OP_ERASE_32B:
         begin
            dec_addr = 1'b1;
            dec_kind = sfcfe_pkg::SFCFE_CMD_ER_32K;
         end
         `SFCFE_OP_CHIP_A, `SFCFE_OP_CHIP_B, `SFCFE_OP_CHIP_OLD: dec_kind = sfcfe_pkg::SFCFE_CMD_CHIP_ER;
         `SFCFE_OP_PROGRAM:
         begin
            dec_addr = 1'b1;
            dec_kind = sfcfe_pkg::SFCFE_CMD_PROGRAM;
         end
         `SFCFE_OP_OTP_PROG:
         begin
            dec_addr = 1'b1;
            dec_kind = sfcfe_pkg::SFCFE_CMD_OTP_PROG;
         end
         `SFCFE_OP_OTP_READ:
         begin
            dec_addr = 1'b1;
            dec_dummy = `SFCFE_DUMMY_TWO;
            dec_kind = sfcfe_pkg::SFCFE_CMD_OTP_READ;
         end
         `SFCFE_OP_STAT_READ: dec_kind = sfcfe_pkg::SFCFE_CMD_STAT_RD;
         `SFCFE_OP_STAT_WR1: dec_kind = sfcfe_pkg::SFCFE_CMD_STAT_WR1;
         `SFCFE_OP_STAT_WR2: dec_kind = sfcfe_pkg::SFCFE_CMD_STAT_WR2;
         `SFCFE_OP_ID_READ: dec_kind = sfcfe_pkg::SFCFE_CMD_ID_READ;
         `SFCFE_OP_ID_OLD: dec_kind = sfcfe_pkg::SFCFE_CMD_ID_OLD;
         `SFCFE_OP_DPD: dec_kind = sfcfe_pkg::SFCFE_CMD_DPD;
         `SFCFE_OP_RESUME: dec_kind = sfcfe_pkg::SFCFE_CMD_RESUME;
         `SFCFE_OP_UDPD: dec_kind = sfcfe_pkg::SFCFE_CMD_DPD;
         `SFCFE_OP_WR_EN, `SFCFE_OP_WR_DIS, `SFCFE_OP_RESET: dec_kind = sfcfe_pkg::SFCFE_CMD_MISC;
         default: dec_known = 1'b0;
      endcase
   end

   // ==========================================================================
   // handy terms
   wire byte_done = sck_rise & (bit_cnt == `SFCFE_BIT_LAST);
   wire udpd_op = (opcode == `SFCFE_OP_UDPD);
   wire reads_status = (cmd_kind == sfcfe_pkg::SFCFE_CMD_STAT_RD) | (cmd_kind == sfcfe_pkg::SFCFE_CMD_ID_READ) |
                       (cmd_kind == sfcfe_pkg::SFCFE_CMD_ID_OLD) | (cmd_kind == sfcfe_pkg::SFCFE_CMD_OTP_READ);
   wire dual_op = (opcode == `SFCFE_OP_READ_DUAL);
   wire [14:0] addr_inc = addr + `SFCFE_ADDR_ONE;
   wire [2:0] out_last = dual ? `SFCFE_DUAL_LAST : `SFCFE_BIT_LAST;
   wire out_byte_end = sck_fall & (bit_cnt == out_last);
   // hand on only when deselected on a byte boundary with all bytes present
   wire frame_ok = (bit_cnt == 3'h0) & (phase == sfcfe_pkg::SFCFE_DATA) & (cmd_kind != sfcfe_pkg::SFCFE_CMD_NONE);
   wire need_data = (cmd_kind == sfcfe_pkg::SFCFE_CMD_PROGRAM) | (cmd_kind == sfcfe_pkg::SFCFE_CMD_OTP_PROG) |
                    (cmd_kind == sfcfe_pkg::SFCFE_CMD_STAT_WR1) | (cmd_kind == sfcfe_pkg::SFCFE_CMD_STAT_WR2);
   wire launch = ~selected & frame_ok & ~reads_status & (~need_data | (data_cnt != 9'h000)) & ~byte_edge;

   // ==========================================================================
   // receive path and phase sequencing
   always_ff @(posedge ref_clk)
   begin
      if (reset | ~selected)
      begin
         phase <= sfcfe_pkg::SFCFE_OPC;
         bit_cnt <= 3'h0;
         addr_cnt <= 2'h0;
         dummy_cnt <= 2'h0;
         data_cnt <= 9'h000;
         dual <= 1'b0;
         if (reset)
            cmd_kind <= sfcfe_pkg::SFCFE_CMD_NONE;
      end
      else if (sck_rise & (phase != sfcfe_pkg::SFCFE_READ) & (phase != sfcfe_pkg::SFCFE_DEAF))
      begin
         shift_in <= op_next;
         bit_cnt <= bit_cnt + 3'h1;
         if (byte_done)
         begin
            unique case (phase)
               sfcfe_pkg::SFCFE_OPC:
               begin
                  opcode <= op_next;
                  cmd_kind <= dec_kind;
                  dummy_cnt <= dec_dummy;
                  phase <= !dec_known ? sfcfe_pkg::SFCFE_DEAF :
                           dec_addr ? sfcfe_pkg::SFCFE_ADDR : sfcfe_pkg::SFCFE_DATA;
               end
               sfcfe_pkg::SFCFE_ADDR:
               begin
                  addr <= {addr[6:0], op_next};
                  addr_cnt <= addr_cnt + 2'h1;
                  if ({1'b0, addr_cnt} == (`SFCFE_ADDR_BYTES - 3'h1))
                     phase <= (dummy_cnt != `SFCFE_DUMMY_NONE) ? sfcfe_pkg::SFCFE_DUMMY :
                              (cmd_kind == sfcfe_pkg::SFCFE_CMD_NONE) ? sfcfe_pkg::SFCFE_READ :
                              sfcfe_pkg::SFCFE_DATA;
               end
               sfcfe_pkg::SFCFE_DUMMY:
               begin
                  dummy_cnt <= dummy_cnt - 2'h1;
                  if (dummy_cnt == `SFCFE_DUMMY_ONE)
                     phase <= (cmd_kind == sfcfe_pkg::SFCFE_CMD_NONE) ? sfcfe_pkg::SFCFE_READ :
                              sfcfe_pkg::SFCFE_DATA;
               end
               sfcfe_pkg::SFCFE_DATA:
               begin
                  last_data <= op_next;
                  if (data_cnt != `SFCFE_PAGE_BYTES)
                     data_cnt <= data_cnt + 9'h001;
               end
               default: phase <= sfcfe_pkg::SFCFE_DEAF;
            endcase
         end
      end
      else if ((phase == sfcfe_pkg::SFCFE_READ) & out_byte_end)
      begin
         bit_cnt <= 3'h0;
         addr <= addr_inc;
      end
      else if ((phase == sfcfe_pkg::SFCFE_READ) & sck_fall)
         bit_cnt <= bit_cnt + 3'h1;
      if (~reset & selected & (phase == sfcfe_pkg::SFCFE_READ) & ~dual & dual_op)
         dual <= 1'b1;
   end

   // ==========================================================================
   // byte_edge guards against handing on a command twice per deselect
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         byte_edge <= 1'b1;
      else
         byte_edge <= ~selected;
   end

   // ==========================================================================
   // transmit path: loads on falling edge, dual shifts two bits
   wire [14:0] rd_addr_next = addr & {`SFCFE_ADDR_W{1'b1}};
   wire load_byte = sck_fall & (bit_cnt == 3'h0);

   always_ff @(posedge ref_clk)
   begin
      rd_addr <= rd_addr_next;
      if (reset | ~selected | (phase != sfcfe_pkg::SFCFE_READ))
      begin
         data_out_oe <= 1'b0;
         second_output_line_oe <= 1'b0;
         data_out <= 1'b0;
         second_output_line_out <= 1'b0;
         out_shift <= 8'h00;
      end
      else if (sck_fall)
      begin
         data_out_oe <= 1'b1;
         second_output_line_oe <= dual;
         if (load_byte)
         begin
            data_out <= rd_data[7];
            second_output_line_out <= rd_data[6];
            out_shift <= dual ? {rd_data[5:0], 2'b00} : {rd_data[6:0], 1'b0};
         end
         else
         begin
            data_out <= out_shift[7];
            second_output_line_out <= out_shift[6];
            out_shift <= dual ? {out_shift[5:0], 2'b00} : {out_shift[6:0], 1'b0};
         end
      end
   end

   // ==========================================================================
   // hand-over pulse to the execution logic
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         cmd_valid <= 1'b0;
         cmd_opcode <= 8'h00;
         cmd_addr <= `SFCFE_ADDR_ZERO;
         cmd_count <= 9'h000;
         cmd_data <= 8'h00;
      end
      else
      begin
         cmd_valid <= launch;
         if (launch)
         begin
            cmd_opcode <= udpd_op ? `SFCFE_OP_UDPD : opcode;
            cmd_addr <= addr;
            cmd_count <= data_cnt;
            cmd_data <= last_data;
         end
      end
   end

endmodule

// file: bench/sfcfe_front_end_chk.sv
/* checker for the command front end, bound to its top module.
   assumes the package is compiled first and reset is synchronous, active high. */
module sfcfe_chk
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // link pins
   input wire logic serial_clk,
   input wire logic chip_sel_n,
   input wire logic second_output_line_in,
   input wire logic second_output_line_out,
   input wire logic second_output_line_oe,
   input wire logic data_out,
   input wire logic data_out_oe,
   // array port
   input wire logic [14:0] rd_addr,
   input wire logic [7:0] rd_data,
   // hand-over
   input wire logic cmd_valid,
   input wire sfcfe_pkg::sfcfe_cmd_e cmd_kind,
   input wire logic [7:0] cmd_opcode,
   input wire logic [14:0] cmd_addr,
   input wire logic [8:0] cmd_count,
   input wire logic [7:0] cmd_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // checks; five cycles covers the synchroniser lag on deselect
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   a_desel_release: assert property (chip_sel_n [*5] |-> !data_out_oe && !second_output_line_oe)
      else $error("line driven while deselected");
   a_dual_pair: assert property (second_output_line_oe |-> data_out_oe)
      else $error("second line without main line");
   a_out_steady: assert property (!chip_sel_n && serial_clk && $past(serial_clk, 3)
      |-> $stable(data_out) && $stable(second_output_line_out))
      else $error("output moved while serial clock high");
   a_valid_pulse: assert property (cmd_valid |=> !cmd_valid)
      else $error("hand-over longer than one cycle");
   a_valid_desel: assert property (cmd_valid |-> chip_sel_n && $past(chip_sel_n, 2))
      else $error("hand-over while selected");
   a_no_read_kind: assert property (cmd_valid |-> !(cmd_kind inside {4'h0, 4'h7, 4'h8, 4'hB, 4'hC}))
      else $error("read command handed on");
   a_small_erase: assert property (cmd_valid |-> (cmd_opcode == 8'h20) == (cmd_kind == sfcfe_pkg::SFCFE_CMD_ER_4K))
      else $error("4K erase class wrong");
   a_block_erase: assert property (cmd_valid && cmd_opcode inside {8'h52, 8'hD8}
      |-> cmd_kind == sfcfe_pkg::SFCFE_CMD_ER_32K)
      else $error("32K erase class wrong");
   a_chip_erase: assert property (cmd_valid && cmd_opcode inside {8'h60, 8'hC7, 8'h62}
      |-> cmd_kind == sfcfe_pkg::SFCFE_CMD_CHIP_ER)
      else $error("chip erase class wrong");
   a_prog_data: assert property (cmd_valid && cmd_kind == sfcfe_pkg::SFCFE_CMD_PROGRAM |-> cmd_count != 9'h000)
      else $error("program handed on without data");
   a_stat_one: assert property (cmd_valid && cmd_opcode inside {8'h01, 8'h31} |-> cmd_count == 9'h001)
      else $error("status write count wrong");
   c_handed: cover property (cmd_valid);
   c_dual: cover property (second_output_line_oe);
   c_read_end: cover property ($fell(data_out_oe));
endmodule

bind sfcfe_front_end sfcfe_chk u_chk (.ref_clk(ref_clk), .reset(reset), .serial_clk(serial_clk),
   .chip_sel_n(chip_sel_n), .second_output_line_in(second_output_line_in),
   .second_output_line_out(second_output_line_out), .second_output_line_oe(second_output_line_oe),
   .data_out(data_out), .data_out_oe(data_out_oe), .rd_addr(rd_addr), .rd_data(rd_data),
   .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
   .cmd_count(cmd_count), .cmd_data(cmd_data));

// file: bench/sfcfe_host.sv
/* host controller model of the serial link, mode 0, clock idle low.
   assumes the bench calls its tasks and ref_clk runs at 50 ns. */
module sfcfe_host
(
   // timing reference
   input wire logic ref_clk,
   // link pins
   output logic sclk,
   output logic cs_n,
   output logic si,
   output logic si_oe,
   input wire logic so,
   input wire logic second_output_line
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // half period of four reference cycles, the least the front end is built for
   task automatic half();
      repeat (4) @(negedge ref_clk);
   endtask
   // data set while the clock is low, taken by the device on the rise
   task automatic put(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--)
      begin
         si <= b[i];
         half();
         sclk <= 1'b1;
         half();
         sclk <= 1'b0;
      end
   endtask
   // sample just before the rise; in dual mode the input line is released
   task automatic get(output logic [7:0] b, input logic dual);
      b = 8'h00;
      si_oe <= !dual;
      for (int i = 0; i < (dual ? 4 : 8); i++)
      begin
         half();
         b = dual ? {b[5:0], so, second_output_line} : {b[6:0], so};
         sclk <= 1'b1;
         half();
         sclk <= 1'b0;
      end
   endtask
   // select or deselect; the data line is taken back only once the device has let go of it
   task automatic frame(input logic open);
      half();
      cs_n <= !open;
      si <= ~si;
      half();
      si_oe <= 1'b1;
   endtask
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      si_oe = 1'b1;
   end
endmodule

// file: bench/tb_top.sv
/* self-checking bench for the command front end.
   assumes the package, design, checker and host model are compiled first. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // design and link signals
   logic ref_clk, reset, sclk, cs_n, h_si, h_si_oe, data_out, data_out_oe, cmd_valid;
   logic second_output_line_out, second_output_line_oe;
   logic [14:0] rd_addr, cmd_addr;
   logic [7:0] rd_data, cmd_opcode, cmd_data, b;
   logic [8:0] cmd_count;
   sfcfe_pkg::sfcfe_cmd_e cmd_kind;
   int n_fail = 0, checked = 0, pulses = 0, cyc = 0, p;
   // released lines float; z matches only where a check expects z
   wire so_w = data_out_oe ? data_out : 1'bz;
   wire sio_w = second_output_line_oe ? second_output_line_out : (h_si_oe ? h_si : 1'bz);
   // array contents depend on every address bit
   function automatic logic [7:0] byte_at(input logic [14:0] a);
      return a[7:0] ^ {1'b0, a[14:8]};
   endfunction
   assign rd_data = byte_at(rd_addr);
   sfcfe_front_end u_sfcfe_front_end (.ref_clk(ref_clk), .reset(reset), .serial_clk(sclk), .chip_sel_n(cs_n),
      .second_output_line_in(sio_w), .second_output_line_out(second_output_line_out),
      .second_output_line_oe(second_output_line_oe), .data_out(data_out), .data_out_oe(data_out_oe),
      .rd_addr(rd_addr), .rd_data(rd_data), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
      .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_count(cmd_count), .cmd_data(cmd_data));
   sfcfe_host u_sfcfe_host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .si(h_si), .si_oe(h_si_oe), .so(so_w),
      .second_output_line(sio_w));
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // pulse count and a ceiling well above the longest expected run;
   // counted on the falling edge, where the one-cycle pulse stands settled
   always @(negedge ref_clk)
   begin
      cyc++;
      if (cmd_valid === 1'b1)
         pulses++;
      if (cyc == 60000)
      begin
         n_fail++;
         end_sim();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, got);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // opcode, address and dummies, then n bytes compared with the array
   task automatic rd(input logic [7:0] op, input logic [23:0] a, input int nd, n, input logic dual);
      u_sfcfe_host.frame(1);
      u_sfcfe_host.put(op, 8);
      for (int i = 2; i >= 0; i--)
         u_sfcfe_host.put(a[8*i+:8], 8);
      repeat (nd) u_sfcfe_host.put(8'hA5, 8);
      for (int i = 0; i < n; i++)
      begin
         u_sfcfe_host.get(b, dual);
         chk("read byte", {8'h00, byte_at(a[14:0] + 15'(i))}, {8'h00, b});
      end
      u_sfcfe_host.frame(0);
   endtask
   // one framed command; hand-over fields judged after deselect
   task automatic cmd(input logic [7:0] op, input int na, nd, input logic [3:0] kind, input int np);
      p = pulses;
      u_sfcfe_host.frame(1);
      u_sfcfe_host.put(op, 8);
      repeat (na) u_sfcfe_host.put(8'hC3, 8);
      for (int i = 1; i <= nd; i++)
         u_sfcfe_host.put(8'(i) ^ 8'h5A, 8);
      u_sfcfe_host.frame(0);
      repeat (8) @(negedge ref_clk);
      chk("pulses", 16'(np), 16'(pulses - p));
      if (np > 0)
      begin
         chk("kind", 16'(kind), 16'(cmd_kind));
         chk("opcode", {8'h00, op}, {8'h00, cmd_opcode});
         chk("count", 16'(nd), {7'h00, cmd_count});
         if (nd > 0)
            chk("data", {8'h00, 8'(nd) ^ 8'h5A}, {8'h00, cmd_data});
         if (na > 0)
            chk("addr", 16'h43C3, {1'b0, cmd_addr});
      end
   endtask
   task automatic t_reads();
      rd(8'h03, 24'hFF7FFE, 0, 4, 1'b0);
      rd(8'h0B, 24'h001234, 1, 2, 1'b0);
      rd(8'h3B, 24'h807FFF, 1, 3, 1'b1);
   endtask
   task automatic t_hand();
      cmd(8'h81, 3, 0, 4'h1, 1);
      cmd(8'h20, 3, 0, 4'h2, 1);
      cmd(8'h52, 3, 0, 4'h3, 1);
      cmd(8'hD8, 3, 1, 4'h3, 1);
      cmd(8'h60, 0, 0, 4'h4, 1);
      cmd(8'hC7, 0, 0, 4'h4, 1);
      cmd(8'h62, 0, 0, 4'h4, 1);
      cmd(8'h02, 3, 256, 4'h5, 1);
      cmd(8'h9B, 3, 2, 4'h6, 1);
      cmd(8'h01, 0, 1, 4'h9, 1);
      cmd(8'h31, 0, 1, 4'hA, 1);
      cmd(8'hB9, 0, 0, 4'hD, 1);
      cmd(8'hAB, 0, 0, 4'hE, 1);
      cmd(8'h79, 0, 0, 4'hD, 1);
   endtask
   // refused, data-returning and cut-short transactions
   task automatic t_refuse();
      cmd(8'h05, 0, 2, 4'h0, 0);
      cmd(8'h9F, 0, 4, 4'h0, 0);
      cmd(8'h15, 0, 2, 4'h0, 0);
      cmd(8'h77, 3, 3, 4'h0, 0);
      cmd(8'h02, 3, 0, 4'h0, 0);
      cmd(8'hE7, 3, 0, 4'h0, 0);
      cmd(8'h20, 2, 0, 4'h0, 0);
      u_sfcfe_host.frame(1);
      u_sfcfe_host.put(8'hE7, 8);
      u_sfcfe_host.put(8'h03, 8);
      u_sfcfe_host.put(8'h00, 8);
      u_sfcfe_host.get(b, 1'b0);
      chk("ignored", 16'h00ZZ, {8'h00, b});
      u_sfcfe_host.frame(0);
      u_sfcfe_host.frame(1);
      u_sfcfe_host.put(8'h03, 8);
      u_sfcfe_host.put(8'h00, 8);
      u_sfcfe_host.put(8'h01, 8);
      u_sfcfe_host.put(8'h00, 8);
      u_sfcfe_host.put(8'h00, 3);
      u_sfcfe_host.frame(0);
      chk("oe", 16'h0000, {14'h0000, data_out_oe, second_output_line_oe});
      p = pulses;
      u_sfcfe_host.frame(1);
      u_sfcfe_host.put(8'h20, 8);
      repeat (3) u_sfcfe_host.put(8'hC3, 8);
      u_sfcfe_host.put(8'h00, 3);
      u_sfcfe_host.frame(0);
      repeat (8) @(negedge ref_clk);
      chk("cut pulses", 16'h0000, 16'(pulses - p));
      rd(8'h03, 24'h000100, 0, 1, 1'b0);
   endtask
   // reset in mid-read drops the lines and leaves nothing to hand on
   task automatic t_reset();
      p = pulses;
      u_sfcfe_host.frame(1);
      u_sfcfe_host.put(8'h03, 8);
      repeat (3) u_sfcfe_host.put(8'h00, 8);
      u_sfcfe_host.put(8'h00, 4);
      reset = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk("oe in reset", 16'h0000, {14'h0000, data_out_oe, second_output_line_oe});
      reset = 1'b0;
      u_sfcfe_host.frame(0);
      repeat (8) @(negedge ref_clk);
      chk("reset pulses", 16'h0000, 16'(pulses - p));
      rd(8'h0B, 24'h007FFF, 1, 2, 1'b0);
   endtask
   initial
   begin
      reset = 1'b1;
      repeat (16) @(negedge ref_clk);
      reset = 1'b0;
      repeat (4) @(negedge ref_clk);
      t_reads();
      t_hand();
      t_refuse();
      t_reset();
      end_sim();
   end
endmodule
